// >>> shared/nvcr_defs.svh
`ifndef NVCR_DEFS_SVH
`define NVCR_DEFS_SVH

`define NVCR_SLAVE_ADDR        7'h4e
`define NVCR_GENERAL_CALL      7'h00
`define NVCR_REG_WIDTH         5
`define NVCR_REG_RESET         5'h00
`define NVCR_VALID_TOP_LSB     5
`define NVCR_CLK_PERIOD_NS     10
`define NVCR_PROG_TIME_US      10000
`define NVCR_PROG_CYCLES       ((`NVCR_PROG_TIME_US * 1000) / `NVCR_CLK_PERIOD_NS)
`define NVCR_SCL_HALF_DEFAULT  125

`endif

// >>> shared/nvcr_pkg.sv
package nvcr_pkg;
	typedef enum logic [2:0] {
		NVCR_IDLE,
		NVCR_ADDR,
		NVCR_ADDR_ACK,
		NVCR_WR_DATA,
		NVCR_WR_ACK,
		NVCR_RD_DATA,
		NVCR_RD_ACK
	} nvcr_slave_state_e;

	typedef enum logic [2:0] {
		NVCRM_IDLE,
		NVCRM_START,
		NVCRM_BIT,
		NVCRM_ACK,
		NVCRM_STOP,
		NVCRM_DONE
	} nvcr_master_state_e;
endpackage

// >>> shared/nvcr_if.sv
`timescale 1ns/10ps
`default_nettype none
interface nvcr_if;
	logic scl_o;
	logic scl_oe_n;
	logic sda_m_o;
	logic sda_m_oe_n;
	logic sda_s_o;
	logic sda_s_oe_n;
	logic scl;
	logic sda;

	modport slave (
		input  scl,
		input  sda,
		output sda_s_o,
		output sda_s_oe_n
	);
	modport master (
		input  scl,
		input  sda,
		output scl_o,
		output scl_oe_n,
		output sda_m_o,
		output sda_m_oe_n
	);
endinterface
`default_nettype wire

// >>> hw/nvcr_slave.sv
`timescale 1ns/10ps
`default_nettype none
`include "nvcr_defs.svh"

// Functional notes
// [RULE1] start: sda falls while scl high
// [RULE2] stop: sda rises while scl high
// [RULE3] sda changes only while scl low
// [RULE4] eight bits then one ack clock
// [RULE5] master sends address msb first, then direction
// [RULE6] direction 0 write, 1 read
// [RULE7] slave only, scl is input only
// [RULE8] respond only to address 1001110
// [RULE9] ignore general call address
// [RULE10] ack holds sda low through scl high
// [RULE11] read returns stored register contents
// [RULE12] valid byte has top three bits zero
// [RULE13] ack invalid byte, never store it
// [RULE14] only first valid byte is stored
// [RULE15] sample wp at first valid ack fall
// [RULE16] program only complete acknowledged bytes
// [RULE17] nack own address while programming
// [RULE18] outputs keep old value while programming
// [RULE19] works to 400 kHz, no stretching
// [RULE20] no clock-low timeout
// [RULE21] every written byte gets device ack
// [RULE22] register resets to all zeros
// [RULE23] low five bits map straight to register
// [RULE24] start or stop mid-byte abandons transfer
module nvcr_slave #(
	parameter int PROG_CYCLES = `NVCR_PROG_CYCLES
) (
	input  wire logic                       clk_i,
	input  wire logic                       arst_n_i,
	nvcr_if.slave                           bus,
	input  wire logic                       write_protect_i,
	output logic [`NVCR_REG_WIDTH-1:0]      config_reg_o,
	output logic [`NVCR_REG_WIDTH-1:0]      selected_config_outputs_o,
	output logic                            busy_o
);
	logic [1:0] scl_sync;
	logic [1:0] sda_sync;
	logic [1:0] wp_sync;
	logic       scl_q;
	logic       sda_q;

	// two flops before any logic reads the pins
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			scl_sync <= 2'b11;
			sda_sync <= 2'b11;
			wp_sync  <= 2'b11;
			scl_q    <= 1'b1;
			sda_q    <= 1'b1;
		end else begin
			scl_sync <= {scl_sync[0], bus.scl};
			sda_sync <= {sda_sync[0], bus.sda};
			wp_sync  <= {wp_sync[0], write_protect_i};
			scl_q    <= scl_sync[1];
			sda_q    <= sda_sync[1];
		end
	end

	wire scl_s    = scl_sync[1];
	wire sda_s    = sda_sync[1];
	wire scl_rise = scl_s & ~scl_q;
	wire scl_fall = ~scl_s & scl_q;
	wire start_c  = scl_s & scl_q & sda_q & ~sda_s; // [RULE1]
	wire stop_c   = scl_s & scl_q & ~sda_q & sda_s; // [RULE2]

	nvcr_pkg::nvcr_slave_state_e state;
	nvcr_pkg::nvcr_slave_state_e next_state;
	logic [7:0]                  shift;
	logic [3:0]                  bit_cnt;
	logic                        sda_low;
	logic                        have_cand;
	logic                        wp_ok;
	logic [`NVCR_REG_WIDTH-1:0]  cand;
	logic [`NVCR_REG_WIDTH-1:0]  nv_reg;
	logic [31:0]                 prog_cnt;
	logic                        acked_valid;

	wire [7:0] shifted    = {shift[6:0], sda_s};
	wire       addr_hit   = (shift[7:1] == `NVCR_SLAVE_ADDR) && !busy_o; // [RULE8] [RULE17]
	wire       byte_valid = (shift[7:`NVCR_VALID_TOP_LSB] == 3'b000); // [RULE12]
	wire       last_bit   = (bit_cnt == 4'd7);

	// general call 0000000 never equals the fixed address, so it is never acked [RULE9]
	always_comb begin
		next_state = state;
		case (state)
			nvcr_pkg::NVCR_IDLE:     next_state = state;
			nvcr_pkg::NVCR_ADDR:     if (scl_fall && bit_cnt == 4'd8)
				next_state = addr_hit ? nvcr_pkg::NVCR_ADDR_ACK : nvcr_pkg::NVCR_IDLE;
			nvcr_pkg::NVCR_ADDR_ACK: if (scl_fall)
				next_state = shift[0] ? nvcr_pkg::NVCR_RD_DATA : nvcr_pkg::NVCR_WR_DATA; // [RULE6]
			nvcr_pkg::NVCR_WR_DATA:  if (scl_fall && bit_cnt == 4'd8)
				next_state = nvcr_pkg::NVCR_WR_ACK;
			nvcr_pkg::NVCR_WR_ACK:   if (scl_fall) next_state = nvcr_pkg::NVCR_WR_DATA;
			nvcr_pkg::NVCR_RD_DATA:  if (scl_fall && last_bit) next_state = nvcr_pkg::NVCR_RD_ACK;
			nvcr_pkg::NVCR_RD_ACK:   if (scl_rise)
				next_state = sda_s ? nvcr_pkg::NVCR_IDLE : nvcr_pkg::NVCR_RD_ACK;
				else if (scl_fall) next_state = nvcr_pkg::NVCR_RD_DATA;
			default:                 next_state = nvcr_pkg::NVCR_IDLE;
		endcase
	end

	// no timeout counter on scl low: state waits for edges forever [RULE20]
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			state   <= nvcr_pkg::NVCR_IDLE;
			shift   <= 8'h00;
			bit_cnt <= 4'd0;
		end else if (start_c) begin
			state   <= nvcr_pkg::NVCR_ADDR; // [RULE24]
			bit_cnt <= 4'd0;
		end else if (stop_c) begin
			state   <= nvcr_pkg::NVCR_IDLE; // [RULE24]
			bit_cnt <= 4'd0;
		end else begin
			state <= next_state;
			if (scl_rise && (state == nvcr_pkg::NVCR_ADDR || state == nvcr_pkg::NVCR_WR_DATA)) begin
				shift   <= shifted; // msb first [RULE5] [RULE4]
				bit_cnt <= bit_cnt + 4'd1;
			end else if (state == nvcr_pkg::NVCR_ADDR_ACK && scl_fall) begin
				bit_cnt <= 4'd0;
				if (shift[0])
					shift <= {3'b000, nv_reg}; // [RULE11]
			end else if (state == nvcr_pkg::NVCR_WR_ACK && scl_fall) begin
				bit_cnt <= 4'd0;
			end else if (state == nvcr_pkg::NVCR_RD_DATA && scl_fall) begin
				shift   <= {shift[6:0], 1'b0};
				bit_cnt <= last_bit ? 4'd0 : bit_cnt + 4'd1;
			end else if (state == nvcr_pkg::NVCR_RD_ACK && scl_fall) begin
				shift <= {3'b000, nv_reg};
			end
		end
	end

	// sda driven only after scl falls, released after the ack fall [RULE3] [RULE19]
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			sda_low <= 1'b0;
		end else if (start_c || stop_c) begin
			sda_low <= 1'b0;
		end else if (scl_fall) begin
			case (next_state)
				nvcr_pkg::NVCR_ADDR_ACK: sda_low <= 1'b1; // [RULE10]
				nvcr_pkg::NVCR_WR_ACK:   sda_low <= 1'b1; // [RULE21] [RULE13]
				// first read bit is the zero pad above the register, so sda goes low
				nvcr_pkg::NVCR_RD_DATA:  sda_low <= (state == nvcr_pkg::NVCR_RD_DATA) ?
					~shift[6] : 1'b1;
				default:                 sda_low <= 1'b0;
			endcase
		end
	end

	// candidate byte, wp sample and programming
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			have_cand   <= 1'b0;
			wp_ok       <= 1'b0;
			acked_valid <= 1'b0;
			cand        <= `NVCR_REG_RESET;
			nv_reg      <= `NVCR_REG_RESET; // [RULE22]
			busy_o      <= 1'b0;
			prog_cnt    <= 32'd0;
		end else begin
			if (start_c) begin
				have_cand   <= 1'b0;
				acked_valid <= 1'b0;
			end else if (state == nvcr_pkg::NVCR_WR_DATA && scl_fall && bit_cnt == 4'd8 &&
				byte_valid && !have_cand) begin
				have_cand <= 1'b1; // [RULE14]
				cand      <= shift[`NVCR_REG_WIDTH-1:0]; // [RULE23]
			end else if (state == nvcr_pkg::NVCR_WR_ACK && scl_fall && have_cand && !acked_valid) begin
				acked_valid <= 1'b1; // [RULE16]
				wp_ok       <= ~wp_sync[1]; // [RULE15]
			end
			if (stop_c && acked_valid && wp_ok && !busy_o) begin
				busy_o      <= 1'b1;
				prog_cnt    <= 32'(PROG_CYCLES);
				acked_valid <= 1'b0;
				have_cand   <= 1'b0;
			end else if (busy_o) begin
				if (prog_cnt <= 32'd1) begin
					busy_o <= 1'b0;
					nv_reg <= cand; // old value shown until the write ends [RULE18]
				end
				prog_cnt <= prog_cnt - 32'd1;
			end
		end
	end

	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			config_reg_o              <= `NVCR_REG_RESET;
			selected_config_outputs_o <= `NVCR_REG_RESET;
		end else begin
			config_reg_o              <= nv_reg;
			selected_config_outputs_o <= nv_reg; // [RULE18]
		end
	end

	// open drain: never drives high, scl has no output at all [RULE7]
	assign bus.sda_s_o    = 1'b0;
	assign bus.sda_s_oe_n = ~sda_low;
endmodule
`default_nettype wire

// >>> hw/nvcr_master.sv
`timescale 1ns/10ps
`default_nettype none
`include "nvcr_defs.svh"

module nvcr_master #(
	parameter int SCL_HALF = `NVCR_SCL_HALF_DEFAULT
) (
	input  wire logic       clk_i,
	input  wire logic       arst_n_i,
	nvcr_if.master          bus,
	input  wire logic       go_i,
	input  wire logic       read_i,
	input  wire logic [6:0] addr_i,
	input  wire logic [7:0] wdata_i,
	output logic [7:0]      rdata_o,
	output logic            ack_ok_o,
	output logic            done_o,
	output logic            busy_o
);
	logic [1:0] sda_sync;
	nvcr_pkg::nvcr_master_state_e state;
	logic [15:0] div;
	logic [1:0]  phase;
	logic [3:0]  bit_cnt;
	logic [7:0]  tx;
	logic        second;
	logic        rd;
	logic        scl_low;
	logic        sda_low;

	wire tick = (div == 16'd0);
	wire sda_s = sda_sync[1];

	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i)
			sda_sync <= 2'b11;
		else
			sda_sync <= {sda_sync[0], bus.sda};
	end

	// quarter-period phases: 0 scl low/set data, 1 scl high, 2 hold high, 3 scl low [RULE3]
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			state    <= nvcr_pkg::NVCRM_IDLE;
			div      <= 16'd0;
			phase    <= 2'd0;
			bit_cnt  <= 4'd0;
			tx       <= 8'h00;
			second   <= 1'b0;
			rd       <= 1'b0;
			scl_low  <= 1'b0;
			sda_low  <= 1'b0;
			rdata_o  <= 8'h00;
			ack_ok_o <= 1'b0;
			done_o   <= 1'b0;
			busy_o   <= 1'b0;
		end else begin
			done_o <= 1'b0;
			div    <= tick ? 16'(SCL_HALF / 2) : div - 16'd1;
			case (state)
				nvcr_pkg::NVCRM_IDLE: if (go_i) begin
					state    <= nvcr_pkg::NVCRM_START;
					busy_o   <= 1'b1;
					rd       <= read_i;
					tx       <= {addr_i, read_i}; // [RULE5] [RULE6]
					second   <= 1'b0;
					phase    <= 2'd0;
					ack_ok_o <= 1'b1;
				end
				nvcr_pkg::NVCRM_START: if (tick) begin
					if (phase == 2'd0) begin
						sda_low <= 1'b1; // [RULE1]
						phase   <= 2'd1;
					end else begin
						// scl falls a quarter later, so the start hold time is kept
						scl_low <= 1'b1;
						state   <= nvcr_pkg::NVCRM_BIT;
						bit_cnt <= 4'd0;
						phase   <= 2'd0;
					end
				end
				nvcr_pkg::NVCRM_BIT: if (tick) begin
					phase <= phase + 2'd1;
					case (phase)
						2'd0: sda_low <= (second && rd) ? 1'b0 : ~tx[7];
						2'd1: scl_low <= 1'b0;
						2'd2: if (second && rd) rdata_o <= {rdata_o[6:0], sda_s};
						default: scl_low <= 1'b1;
					endcase
					if (phase == 2'd3) begin
						tx      <= {tx[6:0], 1'b0};
						bit_cnt <= bit_cnt + 4'd1;
						if (bit_cnt == 4'd7) begin
							state <= nvcr_pkg::NVCRM_ACK; // [RULE4]
							phase <= 2'd0;
						end
					end
				end
				nvcr_pkg::NVCRM_ACK: if (tick) begin
					phase <= phase + 2'd1;
					case (phase)
						2'd0: sda_low <= 1'b0; // nack on the read byte frees sda for the stop
						2'd1: scl_low <= 1'b0;
						2'd2: if (!(second && rd) && sda_s) ack_ok_o <= 1'b0;
						default: scl_low <= 1'b1;
					endcase
					if (phase == 2'd3) begin
						if (second || !ack_ok_o) begin
							state <= nvcr_pkg::NVCRM_STOP;
						end else begin
							state   <= nvcr_pkg::NVCRM_BIT;
							second  <= 1'b1;
							tx      <= wdata_i;
							bit_cnt <= 4'd0;
						end
						phase <= 2'd0;
					end
				end
				nvcr_pkg::NVCRM_STOP: if (tick) begin
					phase <= phase + 2'd1;
					case (phase)
						2'd0: sda_low <= 1'b1;
						2'd1: scl_low <= 1'b0;
						2'd2: sda_low <= 1'b0; // [RULE2]
						default: state <= nvcr_pkg::NVCRM_DONE;
					endcase
				end
				nvcr_pkg::NVCRM_DONE: begin
					done_o <= 1'b1;
					busy_o <= 1'b0;
					state  <= nvcr_pkg::NVCRM_IDLE;
				end
				default: state <= nvcr_pkg::NVCRM_IDLE;
			endcase
		end
	end

	assign bus.scl_o      = 1'b0;
	assign bus.scl_oe_n   = ~scl_low;
	assign bus.sda_m_o    = 1'b0;
	assign bus.sda_m_oe_n = ~sda_low;
endmodule
`default_nettype wire

// >>> testbench/nvcr_assertions.sv
`timescale 1ns/10ps
`default_nettype none
`include "nvcr_defs.svh"
module nvcr_assertions (
	input wire logic clk_i,
	input wire logic arst_n_i,
	input wire logic scl,
	input wire logic sda,
	input wire logic sda_s_o,
	input wire logic sda_s_oe_n
);
	logic       scl_q;
	logic       sda_q;
	logic [3:0] bits;
	logic [1:0] byte_n;
	logic [7:0] sh;
	logic       addr_ok;
	logic       rd;
	wire        start = scl && scl_q && sda_q && !sda;
	wire        rise  = scl && !scl_q;
	wire        ackr  = rise && (bits == 4'h8);
	wire        first = ackr && (byte_n == 2'h0);
	wire        on_d  = (byte_n == 2'h1) && addr_ok;
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!arst_n_i);
	// idle bus reads high, so lines start out high to avoid a false edge
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			{scl_q, sda_q} <= 2'h3;
			{bits, byte_n, sh, addr_ok, rd} <= '0;
		end else begin
			scl_q <= scl;
			sda_q <= sda;
			if (start) begin
				bits   <= 4'h0;
				byte_n <= 2'h0;
			end else if (rise) begin
				sh   <= {sh[6:0], sda};
				bits <= ackr ? 4'h0 : bits + 4'h1;
				if (ackr && byte_n != 2'h3)
					byte_n <= byte_n + 2'h1;
				if (first) begin
					addr_ok <= !sda;
					rd      <= sh[0];
				end
			end
		end
	end
	sequence s_ack_held;
		!sda_s_oe_n [*4];
	endsequence
	property p_addr_miss;
		first && sh[7:1] != `NVCR_SLAVE_ADDR |-> sda_s_oe_n;
	endproperty
	a_addr_miss: assert property (p_addr_miss) else $error("ack on foreign address");
	property p_gcall;
		first && sh[7:1] == `NVCR_GENERAL_CALL |-> sda_s_oe_n;
	endproperty
	a_gcall: assert property (p_gcall) else $error("ack on general call");
	property p_ack_hold;
		ackr && !sda_s_oe_n |-> s_ack_held;
	endproperty
	a_ack_hold: assert property (p_ack_hold) else $error("ack not held");
	property p_low_only;
		!sda_s_oe_n |-> !sda_s_o;
	endproperty
	a_low_only: assert property (p_low_only) else $error("slave drives high");
	property p_edge;
		$changed(sda_s_oe_n) |-> !scl;
	endproperty
	a_edge: assert property (p_edge) else $error("slave sda moved with scl high");
	property p_wr_ack;
		ackr && on_d && !rd |-> !sda_s_oe_n;
	endproperty
	a_wr_ack: assert property (p_wr_ack) else $error("data byte not acked");
	property p_rd_top;
		rise && on_d && rd && bits < 4'h3 |-> !sda_s_oe_n;
	endproperty
	a_rd_top: assert property (p_rd_top) else $error("read top bits not zero");
	property p_rd_free;
		ackr && on_d && rd |-> sda_s_oe_n;
	endproperty
	a_rd_free: assert property (p_rd_free) else $error("slave holds master ack");
endmodule
`default_nettype wire

// >>> testbench/i2c_slave_nv_config_register_test.sv
`timescale 1ns/10ps
`default_nettype none
`include "nvcr_defs.svh"
module i2c_slave_nv_config_register_test;
	localparam int PROG = 2000;
	logic       clk_i    = 1'b0;
	logic       arst_n_i = 1'b0;
	logic       go       = 1'b0;
	logic       rd_sel   = 1'b0;
	logic [7:0] wdata    = 8'h00;
	logic       wp       = 1'b0;
	logic [6:0] addr     = `NVCR_SLAVE_ADDR;
	logic       m_busy;
	logic [7:0] rdata;
	logic       m_ack;
	logic       done;
	logic [4:0] s_cfg;
	logic [4:0] s_sel;
	logic       s_busy;
	logic [4:0] cfg = 5'h00;
	int         failures = 0;
	int         n_tests = 0;
	int         cycles = 0;
	// invalid, protected and high-bit bytes must leave the register alone
	logic [7:0] tbl_d [6] = '{8'h15, 8'h3f, 8'h0a, 8'h1f, 8'h80, 8'h00};
	logic       tbl_wp [6] = '{1'b0, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0};
	logic       tbl_pg [6] = '{1'b1, 1'b0, 1'b0, 1'b1, 1'b0, 1'b1};
	nvcr_if bus ();
	// open-drain wires with pull-up
	assign bus.scl = bus.scl_oe_n | bus.scl_o;
	assign bus.sda = (bus.sda_m_oe_n | bus.sda_m_o) & (bus.sda_s_oe_n | bus.sda_s_o);
	nvcr_slave #(.PROG_CYCLES(PROG)) u_nvcr_slave (
		.clk_i                     (clk_i),
		.arst_n_i                  (arst_n_i),
		.bus                       (bus),
		.write_protect_i           (wp),
		.config_reg_o              (s_cfg),
		.selected_config_outputs_o (s_sel),
		.busy_o                    (s_busy)
	);
	nvcr_master #(.SCL_HALF(20)) u_nvcr_master (
		.clk_i    (clk_i),
		.arst_n_i (arst_n_i),
		.bus      (bus),
		.go_i     (go),
		.read_i   (rd_sel),
		.addr_i   (addr),
		.wdata_i  (wdata),
		.rdata_o  (rdata),
		.ack_ok_o (m_ack),
		.done_o   (done),
		.busy_o   (m_busy)
	);
	nvcr_assertions u_nvcr_assertions (
		.clk_i      (clk_i),
		.arst_n_i   (arst_n_i),
		.scl        (bus.scl),
		.sda        (bus.sda),
		.sda_s_o    (bus.sda_s_o),
		.sda_s_oe_n (bus.sda_s_oe_n)
	);
	always #5 clk_i = ~clk_i;
	task automatic report_and_stop();
		$display("comparisons %0d mismatches %0d", n_tests, failures);
		if (failures == 0 && n_tests > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	always @(posedge clk_i) begin
		cycles++;
		if (cycles == 60000) begin
			failures++;
			report_and_stop();
		end
	end
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		n_tests++;
		if (seen !== exp) begin
			failures++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic xfer(input logic r, input logic [7:0] d);
		@(posedge clk_i);
		go     <= 1'b1;
		rd_sel <= r;
		wdata  <= d;
		@(posedge clk_i);
		go <= 1'b0;
		for (int k = 0; k < 4000 && done !== 1'b1; k++)
			@(negedge clk_i);
		check({7'h0, done}, 8'h01);
		check({7'h0, m_busy}, 8'h00);
	endtask
	initial begin
		repeat (8) @(posedge clk_i);
		arst_n_i <= 1'b1;
		xfer(1'b1, 8'h00);
		check({7'h0, m_ack}, 8'h01);
		check(rdata, 8'h00);
		@(posedge clk_i);
		addr <= 7'h4f;
		xfer(1'b1, 8'h00);
		check({7'h0, m_ack}, 8'h00);
		@(posedge clk_i);
		addr <= `NVCR_GENERAL_CALL;
		xfer(1'b0, 8'h00);
		check({7'h0, m_ack}, 8'h00);
		@(posedge clk_i);
		addr <= `NVCR_SLAVE_ADDR;
		$display("address tests done");
		for (int i = 0; i < 6; i++) begin
			@(posedge clk_i);
			wp <= tbl_wp[i];
			xfer(1'b0, tbl_d[i]);
			check({7'h0, m_ack}, 8'h01);
			repeat (4) @(negedge clk_i);
			check({7'h0, s_busy}, {7'h0, tbl_pg[i]});
			check({3'h0, s_sel}, {3'h0, cfg});
			if (tbl_pg[i]) begin
				xfer(1'b1, 8'h00);
				check({7'h0, m_ack}, 8'h00);
				check({3'h0, s_sel}, {3'h0, cfg});
				cfg = tbl_d[i][4:0];
			end
			for (int k = 0; k < PROG && s_busy !== 1'b0; k++)
				@(negedge clk_i);
			xfer(1'b1, 8'h00);
			check(rdata, {3'h0, cfg});
			check({3'h0, s_cfg}, {3'h0, cfg});
			check({3'h0, s_sel}, {3'h0, cfg});
			$display("test %0d done", i);
		end
		report_and_stop();
	end
endmodule
`default_nettype wire
